// ===== crpm_board_model.sv
/*
  Board side model: reset pins, emulator, watchdog and strap pulls.
  Assumes the bench changes src and straps just after a clock edge.
*/
`default_nettype none

module crpm_board_model (
  // Clock
  input wire logic sys_clk,
  // Bench commands: sys, wdt max, emu max, test pin, reset pin
  input wire logic [4:0] src,
  input wire logic [5:0] straps,
  // Pin role chosen by the device
  input wire logic async_memory_interface,
  // Board outputs
  output logic reset_pin_n,
  output logic test_reset_pin_n,
  output logic emu_max_req,
  output logic wdt_max_req,
  output logic emu_sys_req,
  output logic [5:0] strap_pins
);
  logic [5:0] bus;
  logic [5:0] next_bus;

  // Levels held for as long as the bench asks
  assign reset_pin_n = !src[0];
  assign test_reset_pin_n = !src[1];
  assign emu_max_req = src[2];
  assign wdt_max_req = src[3];
  assign emu_sys_req = src[4];

  // Memory bus traffic moves every cycle, so a late sample is caught
  always_comb next_bus = async_memory_interface ? bus + 6'h15 : ~straps;
  always_ff @(posedge sys_clk) bus <= next_bus;
  assign strap_pins = async_memory_interface ? bus : straps;
endmodule : crpm_board_model

`default_nettype wire

// ===== crpm_checker_asserts.sv
/*
  Port checker for crpm_top, bound below.
  Assumes one clock, sys_clk, and a synchronous reset.
*/
`default_nettype none

module crpm_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Request inputs
  input wire logic reset_pin_n,
  input wire logic emu_max_req,
  input wire logic wdt_max_req,
  input wire logic emu_sys_req,
  input wire crpm_pkg::crpm_module_req_type sw_req,
  input wire crpm_pkg::crpm_module_req_type emu_req,
  input wire logic mux_write,
  input wire logic [2:0] mux_data,
  // Outputs
  input wire crpm_pkg::crpm_resets_type chip_resets,
  input wire logic emu_keep_alive,
  input wire logic [17:0] module_clock_en,
  input wire logic [17:0] module_reset,
  input wire logic [2:0] boot_source_select,
  input wire logic [2:0] address_pin_mux_control,
  input wire logic strap_sample,
  input wire logic async_memory_interface,
  input wire logic pll_enable,
  input wire logic pll_bypass
);
  logic [2:0] idle;
  logic [2:0] next_idle;
  logic busy;
  logic run;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Requests count only after the synchronisers have gone quiet
  assign busy = !reset_pin_n || emu_max_req || wdt_max_req || emu_sys_req;
  assign run = idle == 3'h7 && chip_resets == 3'h0 && !strap_sample;
  always_comb begin
    next_idle = idle + 3'h1;
    if (idle == 3'h7) next_idle = idle;
    if (busy || reset) next_idle = 3'h0;
  end
  always_ff @(posedge sys_clk) idle <= next_idle;

  a_por_widest: assert property (
    chip_resets.por |-> chip_resets.warm && chip_resets.system)
    else $error("por without warm and system");
  a_cold_emu: assert property (
    chip_resets.por |-> !emu_keep_alive) else $error("emu alive in cold");
  a_warm_alive: assert property (
    chip_resets.warm && !chip_resets.por |-> emu_keep_alive)
    else $error("emu link dropped in warm");
  a_pins_revert: assert property (
    async_memory_interface == !strap_sample) else $error("pin role");
  a_pll_bypass: assert property (
    chip_resets.warm |-> !pll_enable && pll_bypass) else $error("pll on");
  a_sys_soft: assert property (
    chip_resets.system && !chip_resets.warm |->
    $stable(module_clock_en) && $stable(pll_bypass))
    else $error("system reset touched clocks");
  a_warm_entry: assert property (
    $rose(chip_resets.warm) |-> module_reset == '1 && module_clock_en == '0)
    else $error("warm entry left modules running");
  a_warm_latency: assert property (
    $fell(reset_pin_n) && run |-> ##[2:5] chip_resets.warm)
    else $error("warm reset late");
  a_sw_module: assert property (
    run && sw_req.valid && !emu_req.valid |=>
    module_clock_en == $past(sw_req.clock_on) &&
    module_reset == $past(sw_req.reset_on)) else $error("sw request lost");
  a_emu_wins: assert property (
    run && emu_req.valid |=> module_clock_en == $past(emu_req.clock_on))
    else $error("emu request lost");
  a_mux_load: assert property (
    run && mux_write |=> address_pin_mux_control == $past(mux_data))
    else $error("mux write lost");
  a_strap_hold: assert property (
    !strap_sample && !$past(strap_sample) |-> $stable(boot_source_select))
    else $error("boot select moved");

  // Main scenarios reached
  c_cold: cover property (chip_resets.por);
  c_system: cover property (chip_resets.system && !chip_resets.warm);
  c_both_req: cover property (run && emu_req.valid && sw_req.valid);
endmodule : crpm_checker

bind crpm_top crpm_checker u_chk (.*);

`default_nettype wire

// ===== crpm_pkg.sv
/*
  Package for the chip reset and module power block: constants, strap
  field layout, module control carriers and the reset scope enumeration.
  Assumes a single reference clock domain and a synchronous reset.
*/
`default_nettype none

package crpm_pkg;

  // Number of managed modules
  localparam int unsigned NUM_MODULES = 18;

  // Strap field layout on the sampled address pins
  localparam int unsigned BOOT_SEL_LSB = 3;
  localparam int unsigned BOOT_SEL_W = 3;
  localparam int unsigned MEM_CFG_LSB = 0;
  localparam int unsigned MEM_CFG_W = 3;
  localparam int unsigned STRAP_W = 6;

  // Reset values
  localparam logic [2:0] BOOT_SEL_RESET = 3'h0;
  localparam logic [2:0] MEM_CFG_RESET = 3'h0;
  localparam logic [NUM_MODULES-1:0] MODULE_CLOCK_RESET = 18'h0_0000;

  // Timing: hold time for a chip reset pulse after all sources release
  localparam int unsigned RESET_HOLD_NS = 1000;
  localparam int unsigned CLOCK_PERIOD_NS = 50;
  localparam int unsigned RESET_HOLD_CYCLES =
    (RESET_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned HOLD_W = 5;

  // Reset scope, narrowest first; a higher code is a wider scope and takes priority
  typedef enum logic [1:0] {
    CRPM_SCOPE_NONE,
    CRPM_SCOPE_SYSTEM,
    CRPM_SCOPE_WARM,
    CRPM_SCOPE_COLD
  } crpm_scope_type;

  // Sequencer states
  typedef enum logic [1:0] {
    CRPM_ST_HOLD,
    CRPM_ST_STRAP,
    CRPM_ST_RUN
  } crpm_state_type;

  // Per-module request from software or emulation
  typedef struct packed {
    logic [NUM_MODULES-1:0] clock_on;
    logic [NUM_MODULES-1:0] reset_on;
    logic valid;
  } crpm_module_req_type;

  // Chip-wide reset outputs
  typedef struct packed {
    logic por;
    logic warm;
    logic system;
  } crpm_resets_type;

endpackage : crpm_pkg

`default_nettype wire

// ===== crpm_top.sv
/*
  Chip reset sequencer and power sleep manager in one module. Holds the
  reset scope arbitration, strap latching, pin mux default, PLL bypass
  defaults and per-module clock and reset gating.
  Assumes the reset pins are asynchronous and active low; software and
  emulation request ports are on sys_clk.
*/
`default_nettype none

module crpm_top (
  // Clock and synchronous reset
  input wire logic sys_clk,
  input wire logic reset,
  // Board reset pins, asynchronous, active low
  input wire logic reset_pin_n,
  input wire logic test_reset_pin_n,
  // Max and system reset requests, asynchronous levels
  input wire logic emu_max_req,
  input wire logic wdt_max_req,
  input wire logic emu_sys_req,
  // Strap pins shared with the memory interface address bus
  input wire logic [crpm_pkg::STRAP_W-1:0] strap_pins,
  // Software and emulation module requests, sys_clk domain
  input wire crpm_pkg::crpm_module_req_type sw_req,
  input wire crpm_pkg::crpm_module_req_type emu_req,
  // Software pin mux override, sys_clk domain
  input wire logic mux_write,
  input wire logic [crpm_pkg::MEM_CFG_W-1:0] mux_data,
  // Reset outputs
  output crpm_pkg::crpm_resets_type chip_resets,
  output logic emu_keep_alive,
  // Module gating
  output logic [crpm_pkg::NUM_MODULES-1:0] module_clock_en,
  output logic [crpm_pkg::NUM_MODULES-1:0] module_reset,
  // Configuration outputs
  output logic [crpm_pkg::BOOT_SEL_W-1:0] boot_source_select,
  output logic [crpm_pkg::MEM_CFG_W-1:0] async_mem_strap_config,
  output logic [crpm_pkg::MEM_CFG_W-1:0] address_pin_mux_control,
  output logic strap_sample,
  output logic async_memory_interface,
  output logic pll_enable,
  output logic pll_bypass
);

  // Two flop synchronisers for the five asynchronous levels
  logic [4:0] sync_first;
  logic [4:0] sync_second;
  logic [crpm_pkg::STRAP_W-1:0] strap_first;
  logic [crpm_pkg::STRAP_W-1:0] strap_second;

  always_ff @(posedge sys_clk) begin
    sync_first <= {~reset_pin_n, ~test_reset_pin_n, emu_max_req,
                   wdt_max_req, emu_sys_req};
    sync_second <= sync_first;
    strap_first <= strap_pins;
    strap_second <= strap_first;
  end

  // Decoded request levels from the second stage only
  logic req_pin;
  logic req_test;
  logic req_max;
  logic req_sys;

  always_comb begin
    req_pin = sync_second[4];
    req_test = sync_second[3];
    req_max = sync_second[2] | sync_second[1];
    req_sys = sync_second[0];
  end

  // Widest requested scope among all active sources
  function automatic crpm_pkg::crpm_scope_type widest_scope(
    input logic pin, input logic test, input logic max_r,
    input logic sys_r);
    crpm_pkg::crpm_scope_type s;
    s = crpm_pkg::CRPM_SCOPE_NONE;
    if (sys_r) begin
      s = crpm_pkg::CRPM_SCOPE_SYSTEM;
    end
    if (max_r || (pin && !test)) begin
      s = crpm_pkg::CRPM_SCOPE_WARM;
    end
    if (pin && test) begin
      s = crpm_pkg::CRPM_SCOPE_COLD;
    end
    return s;
  endfunction : widest_scope

  crpm_pkg::crpm_scope_type req_scope;

  always_comb begin
    req_scope = widest_scope(req_pin, req_test, req_max, req_sys);
  end

  // Sequencer state
  crpm_pkg::crpm_state_type state;
  crpm_pkg::crpm_state_type next_state;
  crpm_pkg::crpm_scope_type scope;
  crpm_pkg::crpm_scope_type next_scope;
  logic [crpm_pkg::HOLD_W-1:0] hold_count;
  logic [crpm_pkg::HOLD_W-1:0] next_hold_count;

  localparam logic [crpm_pkg::HOLD_W-1:0] HOLD_LOAD =
    crpm_pkg::HOLD_W'(crpm_pkg::RESET_HOLD_CYCLES);

  // Scope only widens while any source holds; hold timer restarts on any
  always_comb begin
    next_state = state;
    next_scope = scope;
    next_hold_count = hold_count;
    if (req_scope != crpm_pkg::CRPM_SCOPE_NONE) begin
      next_state = crpm_pkg::CRPM_ST_HOLD;
      next_hold_count = HOLD_LOAD;
      if (req_scope > scope || state == crpm_pkg::CRPM_ST_RUN) begin
        next_scope = (state == crpm_pkg::CRPM_ST_RUN ||
                      req_scope > scope) ? req_scope : scope;
      end
    end else begin
      unique case (state)
        crpm_pkg::CRPM_ST_HOLD: begin
          if (hold_count == '0) begin
            next_state = (scope == crpm_pkg::CRPM_SCOPE_SYSTEM) ?
                         crpm_pkg::CRPM_ST_RUN : crpm_pkg::CRPM_ST_STRAP;
          end else begin
            next_hold_count = hold_count - 1'b1;
          end
        end
        crpm_pkg::CRPM_ST_STRAP: begin
          next_state = crpm_pkg::CRPM_ST_RUN;
        end
        crpm_pkg::CRPM_ST_RUN: begin
          next_scope = crpm_pkg::CRPM_SCOPE_NONE;
        end
        // The fourth code is unused; fall back into hold, timer and scope kept as they are
        default: begin
          next_state = crpm_pkg::CRPM_ST_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= crpm_pkg::CRPM_ST_HOLD;
      scope <= crpm_pkg::CRPM_SCOPE_COLD;
      hold_count <= HOLD_LOAD;
    end else begin
      state <= next_state;
      scope <= next_scope;
      hold_count <= next_hold_count;
    end
  end

  // Reset outputs and configuration, next values
  crpm_pkg::crpm_resets_type next_chip_resets;
  logic next_emu_keep_alive;
  logic in_hold;
  logic chip_wide;
  logic [crpm_pkg::NUM_MODULES-1:0] next_module_clock_en;
  logic [crpm_pkg::NUM_MODULES-1:0] next_module_reset;
  logic [crpm_pkg::BOOT_SEL_W-1:0] next_boot_source_select;
  logic [crpm_pkg::MEM_CFG_W-1:0] next_async_mem_strap_config;
  logic [crpm_pkg::MEM_CFG_W-1:0] next_address_pin_mux_control;
  logic next_strap_sample;
  logic next_async_memory_interface;
  logic next_pll_enable;
  logic next_pll_bypass;

  always_comb begin
    in_hold = (state == crpm_pkg::CRPM_ST_HOLD);
    chip_wide = in_hold && (scope >= crpm_pkg::CRPM_SCOPE_WARM);
    next_chip_resets.por = in_hold &&
                           (scope == crpm_pkg::CRPM_SCOPE_COLD);
    next_chip_resets.warm = chip_wide;
    next_chip_resets.system = in_hold &&
                              (scope != crpm_pkg::CRPM_SCOPE_NONE);
    // Emulator link survives everything but a cold reset
    next_emu_keep_alive = !next_chip_resets.por;

    next_module_clock_en = module_clock_en;
    next_module_reset = module_reset;
    next_boot_source_select = boot_source_select;
    next_async_mem_strap_config = async_mem_strap_config;
    next_address_pin_mux_control = address_pin_mux_control;
    next_pll_enable = pll_enable;
    next_pll_bypass = pll_bypass;
    // Straps are driven only outside run; pins hand back afterwards
    // Next scope, so a soft reset entered from run never flips the pins
    next_strap_sample = (next_state != crpm_pkg::CRPM_ST_RUN) &&
                        (next_scope != crpm_pkg::CRPM_SCOPE_SYSTEM);
    next_async_memory_interface = !next_strap_sample;

    if (chip_wide) begin
      // System reset skips this branch, so clocks and power are kept
      next_module_clock_en = crpm_pkg::MODULE_CLOCK_RESET;
      next_module_reset = '1;
      next_pll_enable = 1'b0;
      next_pll_bypass = 1'b1;
    end else if (in_hold) begin
      next_module_reset = '1;
      // Soft reset skips the strap cycle, so modules leave reset here
      if (next_state == crpm_pkg::CRPM_ST_RUN) begin
        next_module_reset = '0;
      end
    end else if (state == crpm_pkg::CRPM_ST_STRAP) begin
      next_boot_source_select = strap_second[crpm_pkg::BOOT_SEL_LSB +:
                                             crpm_pkg::BOOT_SEL_W];
      next_async_mem_strap_config = strap_second[crpm_pkg::MEM_CFG_LSB +:
                                                 crpm_pkg::MEM_CFG_W];
      next_address_pin_mux_control = strap_second[crpm_pkg::MEM_CFG_LSB +:
                                                  crpm_pkg::MEM_CFG_W];
      next_module_reset = '0;
    end else begin
      // Emulation request is applied after software, so it wins
      if (sw_req.valid) begin
        next_module_clock_en = sw_req.clock_on;
        next_module_reset = sw_req.reset_on;
      end
      if (emu_req.valid) begin
        next_module_clock_en = emu_req.clock_on;
        next_module_reset = emu_req.reset_on;
      end
      if (mux_write) begin
        next_address_pin_mux_control = mux_data;
      end
    end
  end

  // Output registers; strap pull defaults until first sample
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      chip_resets <= '{por: 1'b1, warm: 1'b1, system: 1'b1};
      emu_keep_alive <= 1'b0;
      module_clock_en <= crpm_pkg::MODULE_CLOCK_RESET;
      module_reset <= '1;
      boot_source_select <= crpm_pkg::BOOT_SEL_RESET;
      async_mem_strap_config <= crpm_pkg::MEM_CFG_RESET;
      address_pin_mux_control <= crpm_pkg::MEM_CFG_RESET;
      strap_sample <= 1'b1;
      async_memory_interface <= 1'b0;
      pll_enable <= 1'b0;
      pll_bypass <= 1'b1;
    end else begin
      chip_resets <= next_chip_resets;
      emu_keep_alive <= next_emu_keep_alive;
      module_clock_en <= next_module_clock_en;
      module_reset <= next_module_reset;
      boot_source_select <= next_boot_source_select;
      async_mem_strap_config <= next_async_mem_strap_config;
      address_pin_mux_control <= next_address_pin_mux_control;
      strap_sample <= next_strap_sample;
      async_memory_interface <= next_async_memory_interface;
      pll_enable <= next_pll_enable;
      pll_bypass <= next_pll_bypass;
    end
  end

endmodule : crpm_top

`default_nettype wire

// ===== test_chip_reset_and_module_power_control.sv
/*
  Bench for crpm_top with the board model on pins and straps.
  Assumes sys_clk at 20 MHz; inputs move 5 ns after rising edges.
*/
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD %0t got %h exp %h", $time, (a), (e)); end end

module test_chip_reset_and_module_power_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] src = 5'h00;
  logic [5:0] straps = 6'h2B;
  logic mux_write = 1'b0;
  logic [2:0] mux_data = 3'h0;
  crpm_pkg::crpm_module_req_type sw_req = '0;
  crpm_pkg::crpm_module_req_type emu_req = '0;
  logic reset_pin_n, test_reset_pin_n, emu_max_req, wdt_max_req;
  logic emu_sys_req, emu_keep_alive, strap_sample;
  logic async_memory_interface, pll_enable, pll_bypass;
  logic [5:0] strap_pins;
  crpm_pkg::crpm_resets_type chip_resets;
  logic [17:0] module_clock_en;
  logic [17:0] module_reset;
  logic [2:0] boot_source_select;
  logic [2:0] async_mem_strap_config;
  logic [2:0] address_pin_mux_control;
  logic [4:0] warm_src [3] = '{5'h01, 5'h04, 5'h08};
  int n_mismatch = 0;
  int checks = 0;

  crpm_top DUT (.*);
  crpm_board_model u_board (.*);

  initial forever #25 sys_clk = ~sys_clk;

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask : step

  // Bounded wait for the hold timer and strap cycle to finish
  task automatic wait_run;
    for (int i = 0; i < 80 && (chip_resets !== 3'h0 ||
         strap_sample !== 1'b0); i++) step(1);
    `CHK(chip_resets, 3'h0)
    step(4);
  endtask : wait_run

  task automatic t_power_up;
    wait_run();
    `CHK(boot_source_select, 3'h5)
    `CHK(async_mem_strap_config, 3'h3)
    `CHK(address_pin_mux_control, 3'h3)
    `CHK({pll_enable, pll_bypass}, 2'h1)
    `CHK(async_memory_interface, 1'b1)
    $display("done power_up");
  endtask : t_power_up

  task automatic t_modules;
    sw_req = {18'h0_0F0F, 18'h3_0000, 1'b1};
    step(1);
    `CHK(module_clock_en, 18'h0_0F0F)
    `CHK(module_reset, 18'h3_0000)
    sw_req = {18'h0_00FF, 18'h0_0000, 1'b1};
    emu_req = {18'h3_0001, 18'h0_0002, 1'b1};
    step(1);
    sw_req.valid = 1'b0;
    emu_req.valid = 1'b0;
    `CHK(module_clock_en, 18'h3_0001)
    `CHK(module_reset, 18'h0_0002)
    mux_write = 1'b1;
    mux_data = 3'h6;
    step(1);
    mux_write = 1'b0;
    `CHK(address_pin_mux_control, 3'h6)
    $display("done modules");
  endtask : t_modules

  task automatic t_system;
    src = 5'h10;
    step(3);
    `CHK(async_memory_interface, 1'b1)
    // Module requests during the hold must be refused
    sw_req = {18'h0_0003, 18'h0_0000, 1'b1};
    step(5);
    sw_req.valid = 1'b0;
    `CHK(chip_resets, 3'h1)
    `CHK(module_clock_en, 18'h3_0001)
    `CHK(module_reset, 18'h3_FFFF)
    src = 5'h00;
    wait_run();
    `CHK(module_clock_en, 18'h3_0001)
    `CHK(module_reset, 18'h0_0000)
    $display("done system");
  endtask : t_system

  // Pin, emulator and watchdog each give the same warm scope
  task automatic t_warm;
    foreach (warm_src[k]) begin
      straps = 6'(k * 8 + 6);
      src = warm_src[k];
      step(8);
      `CHK(chip_resets, 3'h3)
      `CHK(emu_keep_alive, 1'b1)
      `CHK(module_clock_en, 18'h0_0000)
      `CHK(strap_sample, 1'b1)
      src = 5'h00;
      wait_run();
      `CHK(boot_source_select, 3'(k))
      `CHK(async_mem_strap_config, 3'h6)
    end
    $display("done warm");
  endtask : t_warm

  task automatic t_cold;
    src = 5'h02;
    step(8);
    `CHK(chip_resets, 3'h0)
    src = 5'h11;
    step(8);
    `CHK(chip_resets, 3'h3)
    src = 5'h13;
    step(8);
    `CHK(chip_resets, 3'h7)
    `CHK(emu_keep_alive, 1'b0)
    src = 5'h10;
    step(30);
    `CHK(chip_resets.system, 1'b1)
    src = 5'h00;
    wait_run();
    `CHK(emu_keep_alive, 1'b1)
    $display("done cold");
  endtask : t_cold

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  // Main sequence after 3 cycles of reset
  initial begin
    step(3);
    reset = 1'b0;
    t_power_up();
    t_modules();
    t_system();
    t_warm();
    t_cold();
    finish_test();
  end

  // About 260 cycles are needed; 2000 allows for slow release
  initial begin
    #(2000 * 50);
    n_mismatch++;
    finish_test();
  end
endmodule : test_chip_reset_and_module_power_control

`default_nettype wire
